// ---- include/clk_seq_pkg.sv ----
// shared constants and carriers for the start-up and output sequencer
package clk_seq_pkg;

  // output count and divider width
  localparam int unsigned NUM_OUT   = 8;
  localparam int unsigned DIV_WIDTH = 10;
  localparam int unsigned CNT_WIDTH = 24;

  // clock rate of ref_clk, used to turn times into cycles
  localparam int unsigned CLK_FREQ_KHZ = 200000;

  // start-up step lengths in phase detector cycles / feedback edges
  localparam int unsigned REF_COUNT_CYCLES = 65536;
  localparam int unsigned FB_COUNT_EDGES   = 65536;
  localparam int unsigned CAL_CYCLES       = 131072;

  // lock indicator window after outputs turn on, and chosen point in it
  localparam int unsigned LOCK_MIN_CYCLES = 2048;
  localparam int unsigned LOCK_MAX_CYCLES = 2560;
  localparam int unsigned LOCK_CYCLES     = 2304;

  // internal ramp guard: least time from release to calibration start
  localparam int unsigned RAMP_TIME_MS = 50;
  localparam int unsigned RAMP_CYCLES  = RAMP_TIME_MS * CLK_FREQ_KHZ;

  // outputs aligned to the first prescaler; the rest follow the second
  localparam logic [7:0] GROUP_ONE_MASK = 8'h33;

  // outputs with the bypass mux
  localparam int unsigned MUX_OUT_LO = 4;
  localparam int unsigned MUX_OUT_HI = 5;

  // values after reset
  localparam logic [7:0] OUT_OE_N_RESET = 8'hFF;
  localparam logic [7:0] OUT_VAL_RESET  = 8'h00;

  // selection for a muxed output
  typedef struct packed {
    logic bypass;       // forward an input clock instead of the divider
    logic useSecondary; // which input clock to forward
  } bypass_cfg_s;

  // prescaler strobes and their relation
  typedef struct packed {
    logic oneTick;      // pulse from the first prescaler
    logic twoTick;      // pulse from the second prescaler
    logic sameRatio;    // both prescalers share one divide value
  } prescaler_s;

endpackage : clk_seq_pkg

// ---- core/clk_out_divider.sv ----
// one output divider clocked by prescaler strobes
`timescale 1ns/100ps
`default_nettype none

module clk_out_divider #(
  parameter int unsigned WIDTH = 10
) (
  input  wire logic             ref_clk, // phase detector reference clock
  input  wire logic             rstn,    // async reset, active low
  input  wire logic             clear,   // hold divider at phase zero
  input  wire logic             tick,    // prescaler strobe
  input  wire logic [WIDTH-1:0] ratio,   // divide count, zero acts as one
  output logic                  clkOut   // divided level
);

  logic [WIDTH-1:0] cnt_r;

  // count strobes, toggle the level at the end of each half period
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      clkOut <= 1'b0;
    end else if (clear) begin
      cnt_r  <= '0;
      clkOut <= 1'b0;
    end else if (tick) begin
      if (cnt_r + WIDTH'(1) >= ratio) begin
        cnt_r  <= '0;
        clkOut <= ~clkOut;
      end else begin
        cnt_r <= cnt_r + WIDTH'(1);
      end
    end
  end

endmodule : clk_out_divider

`default_nettype wire

// ---- core/clock_output_startup_sync_sequencer.sv ----
// start-up, calibration and sync release sequencer for eight outputs
//
// Behaviour
// RQ1 - outputs 0,1,4,5 follow prescaler one, others two
// RQ2 - equal prescalers release all eight outputs together
// RQ3 - equal settings: skew within one prescaler cycle
// RQ4 - differing settings: skew within two cycles
// RQ5 - outputs 4,5 pick divider or bypassed input clock; code picks fracResult, not the divider, when not bypassed
// RQ6 - host disables all, then enables outputs singly
// RQ7 - start-up counters expire before calibration begins
// RQ8 - slow supplies: system holds power-down input low
// RQ9 - toggling power-down or reset restarts whole sequence
// RQ10 - fast ramps: calibration delayed by internal timer
// RQ11 - sync: outputs high-z, dividers reset, retimed release
// RQ12 - count reference cycles, then equal feedback cycles
// RQ13 - calibrate fixed cycles, then outputs on immediately
// RQ14 - lock indicator rises within window after turn-on
// RQ15 - synchronous to reference; pins asynchronously restart it
// RQ16 - each output enable keeps disabled output high-z
`timescale 1ns/100ps
`default_nettype none

module clock_output_startup_sync_sequencer #(
  parameter int unsigned REF_CYCLES  = clk_seq_pkg::REF_COUNT_CYCLES,
  parameter int unsigned FB_EDGES    = clk_seq_pkg::FB_COUNT_EDGES,
  parameter int unsigned CAL_CYCLES  = clk_seq_pkg::CAL_CYCLES,
  parameter int unsigned RAMP_CYCLES = clk_seq_pkg::RAMP_CYCLES,
  parameter int unsigned DIV_W       = clk_seq_pkg::DIV_WIDTH
) (
  input  wire logic                     ref_clk,           // pfd reference
  input  wire logic                     rstn,              // async reset
  input  wire logic                     porReleased,       // supply ok pin
  input  wire logic                     powerDownLowInput, // pin, low=off
  input  wire logic                     resetLowInput,     // pin, low=rst
  input  wire logic                     dividerRealignLow, // sync pin
  input  wire logic                     feedbackClock,     // feedback pin
  input  wire logic                     primaryClock,      // input clock
  input  wire logic                     secondaryClock,    // input clock
  input  wire clk_seq_pkg::prescaler_s  prescaler,         // strobes
  input  wire logic [DIV_W*8-1:0]       divRatio,          // per output
  input  wire logic [7:0]               outEnable,         // per output
  input  wire logic [1:0]               fracResult,        // outputs 4,5
  input  wire clk_seq_pkg::bypass_cfg_s [1:0] bypassCfg,   // outputs 4,5
  output logic [7:0]                    clkOut,            // output levels
  output logic [7:0]                    clkOeN,            // low = driven
  output logic                          lockOut,           // lock flag
  output logic                          calibrating        // cal running
);

  typedef enum logic [2:0] {
    REF_COUNT, FB_COUNT, RAMP_WAIT, CALIBRATE, RUNNING
  } seq_state_e;

  localparam int unsigned CW = clk_seq_pkg::CNT_WIDTH;

  ////////////////////////////////////////////////////////////////////////
  // reset: any of the release pins drops the sequencer back to the start

  logic seqRstRaw;
  logic rstMeta_r;
  logic seqRstN_r;

  // asynchronous entry, release retimed by two flops
  assign seqRstRaw = rstn & porReleased & powerDownLowInput
                     & resetLowInput; // [RQ15] [RQ9]

  always_ff @(posedge ref_clk or negedge seqRstRaw) begin
    if (!seqRstRaw) begin
      rstMeta_r <= 1'b0;
      seqRstN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      seqRstN_r <= rstMeta_r; // [RQ15]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic       fbPrev_r;
  logic       fbEdge;
  logic       realignLow;
  logic       priLvl;
  logic       secLvl;

  // two flops on the sync, feedback and input clock pins before use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_r <= 4'h1; // sync pin idles high, so no false release edge
      pinSync_r <= 4'h1;
      fbPrev_r  <= 1'b0;
    end else begin
      pinMeta_r <= {secondaryClock, primaryClock, feedbackClock,
                    dividerRealignLow};
      pinSync_r <= pinMeta_r;
      fbPrev_r  <= pinSync_r[1];
    end
  end

  assign realignLow = pinSync_r[0];
  assign fbEdge     = pinSync_r[1] & ~fbPrev_r;
  assign priLvl     = pinSync_r[2];
  assign secLvl     = pinSync_r[3];

  ////////////////////////////////////////////////////////////////////////
  // start-up state machine

  seq_state_e    state_r;
  seq_state_e    state_nxt;
  logic [CW-1:0] stepCnt_r;
  logic [CW-1:0] rampCnt_r;
  logic          rampDone_r;
  logic          stepEnd;

  // end of the current counted step
  always_comb begin
    case (state_r)
      REF_COUNT: stepEnd = stepCnt_r == CW'(REF_CYCLES - 1);
      FB_COUNT:  stepEnd = fbEdge && stepCnt_r == CW'(FB_EDGES - 1);
      RAMP_WAIT: stepEnd = rampDone_r;
      CALIBRATE: stepEnd = stepCnt_r == CW'(CAL_CYCLES - 1);
      default:   stepEnd = 1'b0;
    endcase
  end

  // step order: reference, feedback, ramp guard, calibration, run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      REF_COUNT: if (stepEnd) state_nxt = FB_COUNT;   // [RQ12]
      FB_COUNT:  if (stepEnd) state_nxt = RAMP_WAIT;  // [RQ12]
      RAMP_WAIT: if (stepEnd) state_nxt = CALIBRATE;  // [RQ7] [RQ10]
      CALIBRATE: if (stepEnd) state_nxt = RUNNING;    // [RQ13]
      RUNNING:   state_nxt = RUNNING;
      default:   state_nxt = REF_COUNT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      state_r <= REF_COUNT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // step counter, restarted on each change of step
  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      stepCnt_r <= '0;
    end else if (state_nxt != state_r) begin
      stepCnt_r <= '0;
    end else if (state_r == REF_COUNT || state_r == CALIBRATE) begin
      stepCnt_r <= stepCnt_r + CW'(1); // [RQ12] [RQ13]
    end else if (state_r == FB_COUNT && fbEdge) begin
      stepCnt_r <= stepCnt_r + CW'(1); // [RQ12]
    end
  end

  // ramp guard timer runs from release alongside the counters
  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      rampCnt_r  <= '0;
      rampDone_r <= 1'b0;
    end else if (!rampDone_r) begin
      rampCnt_r  <= rampCnt_r + CW'(1);
      rampDone_r <= rampCnt_r == CW'(RAMP_CYCLES - 1); // [RQ10]
    end
  end

  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      calibrating <= 1'b0;
    end else begin
      calibrating <= state_nxt == CALIBRATE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock indicator

  logic [11:0] lockCnt_r;

  // count from output turn-on, flag lock inside the window
  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      lockCnt_r <= '0;
      lockOut   <= 1'b0;
    end else if (state_r == RUNNING && !lockOut) begin
      lockCnt_r <= lockCnt_r + 12'h001;
      lockOut   <= lockCnt_r == 12'(clk_seq_pkg::LOCK_CYCLES - 1); // [RQ14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync handling and group release

  logic       syncHeld;
  logic       realignPrev_r;
  logic       pendOne_r;
  logic       pendTwo_r;
  logic [1:0] groupOn_r;
  logic       relOne;
  logic       relTwo;

  assign syncHeld = !realignLow;

  // equal prescalers: both groups wait for the first prescaler strobe
  assign relOne = prescaler.oneTick; // [RQ1]
  assign relTwo = prescaler.sameRatio ? prescaler.oneTick
                                      : prescaler.twoTick; // [RQ2] [RQ4]

  // latch the release edge, hold it until the group's prescaler strobe
  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      realignPrev_r <= 1'b1;
      pendOne_r     <= 1'b0;
      pendTwo_r     <= 1'b0;
      groupOn_r     <= 2'b00;
    end else begin
      realignPrev_r <= realignLow;
      if (state_r == CALIBRATE && stepEnd) begin
        groupOn_r <= 2'b11; // [RQ13]
      end else if (syncHeld) begin
        groupOn_r <= 2'b00; // [RQ11]
        pendOne_r <= 1'b0;
        pendTwo_r <= 1'b0;
      end else begin
        if (pendOne_r && relOne) begin
          groupOn_r[0] <= 1'b1; // [RQ1] [RQ3]
          pendOne_r    <= 1'b0;
        end
        if (pendTwo_r && relTwo) begin
          groupOn_r[1] <= 1'b1; // [RQ1] [RQ2]
          pendTwo_r    <= 1'b0;
        end
        if (realignLow && !realignPrev_r) begin
          pendOne_r <= 1'b1; // [RQ11]
          pendTwo_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output dividers, bypass mux and drivers

  logic [7:0] divLvl;
  logic [7:0] outLvl;
  logic [7:0] outOn;

  for (genvar i = 0; i < 8; i++) begin : g_div
    localparam bit IN_ONE = clk_seq_pkg::GROUP_ONE_MASK[i];
    clk_out_divider #(.WIDTH(DIV_W)) u_div (
      .ref_clk (ref_clk),
      .rstn    (seqRstN_r),
      .clear   (syncHeld || state_r != RUNNING), // [RQ11]
      .tick    (IN_ONE ? relOne : relTwo),       // [RQ1]
      .ratio   (divRatio[i*DIV_W +: DIV_W]),
      .clkOut  (divLvl[i])
    );
    assign outOn[i] = groupOn_r[IN_ONE ? 0 : 1] && state_r == RUNNING
                      && outEnable[i] && !syncHeld; // [RQ16] [RQ11]
  end

  // outputs 4 and 5 may forward an input clock past the pll
  always_comb begin
    outLvl = divLvl;
    for (int k = 0; k < 2; k++) begin
      if (bypassCfg[k].bypass) begin
        outLvl[clk_seq_pkg::MUX_OUT_LO + k] =
          bypassCfg[k].useSecondary ? secLvl : priLvl; // [RQ5]
      end else begin
        outLvl[clk_seq_pkg::MUX_OUT_LO + k] = fracResult[k]; // [RQ5]
      end
    end
  end

  // registered output levels and enables, high-z when not released
  always_ff @(posedge ref_clk or negedge seqRstN_r) begin
    if (!seqRstN_r) begin
      clkOut <= clk_seq_pkg::OUT_VAL_RESET;
      clkOeN <= clk_seq_pkg::OUT_OE_N_RESET;
    end else begin
      clkOut <= outLvl & outOn;
      clkOeN <= ~outOn; // [RQ16] [RQ6]
    end
  end

endmodule : clock_output_startup_sync_sequencer

`default_nettype wire

// ---- tb/clk_seq_assertions.sv ----
// checker for the start-up and sync sequencer
`timescale 1ns/100ps
`default_nettype none
module clk_seq_assertions #(
  parameter int unsigned REF_CYCLES  = 16,
  parameter int unsigned FB_EDGES    = 8,
  parameter int unsigned CAL_CYCLES  = 32,
  parameter int unsigned RAMP_CYCLES = 20
) (
  input wire logic                    ref_clk,           // clock
  input wire logic                    rstn,              // reset
  input wire logic                    porReleased,       // supply ok
  input wire logic                    powerDownLowInput, // power-down
  input wire logic                    resetLowInput,     // reset pin
  input wire logic                    dividerRealignLow, // sync pin
  input wire clk_seq_pkg::prescaler_s prescaler,         // strobes
  input wire logic [7:0]              outEnable,         // enables
  input wire logic [7:0]              clkOut,            // levels
  input wire logic [7:0]              clkOeN,            // low = driven
  input wire logic                    lockOut,           // lock flag
  input wire logic                    calibrating        // cal running
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic   pinsOk = porReleased & powerDownLowInput & resetLowInput;
  int unsigned upCnt, onCnt, calCnt;
  logic        seenSync;
  ////////////////////////////////////////////////////////////////////////
  // cycle counts since release, in and after calibration
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      upCnt    <= 0;
      onCnt    <= 0;
      calCnt   <= 0;
      seenSync <= 1'b0;
    end else begin
      upCnt    <= pinsOk ? upCnt + 1 : 0;
      calCnt   <= calibrating ? calCnt + 1 : 0;
      onCnt    <= (pinsOk && !calibrating) ? onCnt + 1 : 0;
      seenSync <= pinsOk && (seenSync || !dividerRealignLow);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (
    !pinsOk |-> clkOeN == 8'hFF && clkOut == 8'h00 && !lockOut && !calibrating)
    else $error("outputs active while held in reset");
  a_cal_order: assert property (
    $rose(calibrating) |-> upCnt > REF_CYCLES + FB_EDGES && upCnt >= RAMP_CYCLES)
    else $error("calibration started too early");
  a_cal_length: assert property (
    $fell(calibrating) && pinsOk |-> calCnt == CAL_CYCLES)
    else $error("calibration length wrong");
  a_cal_hiz: assert property (
    calibrating |-> clkOeN == 8'hFF) else $error("output on in calibration");
  a_turn_on: assert property (
    $fell(calibrating) && pinsOk && !seenSync
      |-> ##[1:3] (clkOeN & outEnable) == 8'h00)
    else $error("outputs late after calibration");
  a_lock_window: assert property (
    $rose(lockOut) |-> onCnt >= clk_seq_pkg::LOCK_MIN_CYCLES
      && onCnt <= clk_seq_pkg::LOCK_MAX_CYCLES) else $error("lock off window");
  a_lock_held: assert property (
    lockOut && pinsOk ##1 pinsOk |-> lockOut) else $error("lock dropped");
  a_sync_hiz: assert property (
    !dividerRealignLow [*5] |-> clkOeN == 8'hFF) else $error("driven in sync");
  a_disabled_hiz: assert property (
    (~outEnable & ~$past(outEnable) & ~clkOeN) == 8'h00)
    else $error("disabled output driven");
  a_group_one: assert property (
    seenSync && $fell(clkOeN[0]) && $past(outEnable[0], 2)
      |-> $past(prescaler.oneTick, 2)) else $error("group one misaligned");
  a_group_two: assert property (
    seenSync && $fell(clkOeN[2]) && $past(outEnable[2], 2) |-> $past(
      prescaler.twoTick | prescaler.oneTick & prescaler.sameRatio, 2))
    else $error("group two misaligned");
endmodule : clk_seq_assertions
bind clock_output_startup_sync_sequencer clk_seq_assertions #(
  .REF_CYCLES(REF_CYCLES), .FB_EDGES(FB_EDGES), .CAL_CYCLES(CAL_CYCLES),
  .RAMP_CYCLES(RAMP_CYCLES)) i_chk (.ref_clk, .rstn, .porReleased,
  .powerDownLowInput, .resetLowInput, .dividerRealignLow, .prescaler,
  .outEnable, .clkOut, .clkOeN, .lockOut, .calibrating);
`default_nettype wire

// ---- tb/clk_seq_far_model.sv ----
// far side: free-running feedback clock and prescaler strobes
`timescale 1ns/100ps
`default_nettype none
module clk_seq_far_model (
  input  wire logic               ref_clk,       // reference clock
  input  wire logic               rstn,          // reset
  input  wire logic               sameRatio,     // equal divide values
  output logic                    feedbackClock, // runs free
  output var clk_seq_pkg::prescaler_s prescaler  // strobes
);
  logic [7:0] phase;
  logic [2:0] twoCnt;
  wire logic  one = phase[1:0] == 2'h3;
  // phase counters of both prescalers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase  <= 8'h00;
      twoCnt <= 3'h0;
    end else begin
      phase  <= phase + 8'h01;
      twoCnt <= (twoCnt == 3'h6) ? 3'h0 : twoCnt + 3'h1;
    end
  end
  // feedback period of four cycles, strobes every four and seven
  assign feedbackClock = phase[1];
  assign prescaler = {one, sameRatio ? one : twoCnt == 3'h6, sameRatio};
endmodule : clk_seq_far_model
`default_nettype wire

// ---- tb/tb_clock_output_startup_sync_sequencer.sv ----
// testbench for the start-up and sync sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_clock_output_startup_sync_sequencer;
  localparam int CAL_C = 32;
  logic                           ref_clk, rstn, porReleased, sameRatio;
  logic                           powerDownLowInput, resetLowInput;
  logic                           dividerRealignLow, feedbackClock;
  logic                           primaryClock, secondaryClock;
  logic                           lockOut, calibrating;
  logic [1:0]                     fracResult;
  logic [7:0]                     clkOut, clkOeN, outEnable;
  logic [79:0]                    divRatio;
  clk_seq_pkg::prescaler_s        prescaler;
  clk_seq_pkg::bypass_cfg_s [1:0] bypassCfg;
  int                             mismatches, total_checks, n, t0, t2;
  clock_output_startup_sync_sequencer #(.REF_CYCLES(16), .FB_EDGES(8),
    .CAL_CYCLES(CAL_C), .RAMP_CYCLES(20)) i_dut (.ref_clk, .rstn,
    .porReleased, .powerDownLowInput, .resetLowInput, .dividerRealignLow,
    .feedbackClock, .primaryClock, .secondaryClock, .prescaler, .divRatio,
    .outEnable, .fracResult, .bypassCfg, .clkOut, .clkOeN, .lockOut,
    .calibrating);
  clk_seq_far_model i_far (.ref_clk, .rstn, .sameRatio, .feedbackClock,
    .prescaler);
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // expected enables: enabled outputs driven, the rest high-z
  function automatic logic [7:0] expOeN(input logic [7:0] en);
    return ~en;
  endfunction : expOeN
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  // bounded wait on calibrating (0) or lockOut (1), cycles in m
  task automatic waitFor(input int s, input logic v, output int m);
    m = 0;
    while ((s == 0 ? calibrating : lockOut) !== v) begin
      tick(1);
      m++;
      if (m > 4000) begin
        mismatches++;
        summarize();
      end
    end
  endtask : waitFor
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    {rstn, porReleased, powerDownLowInput, sameRatio} = 4'h0;
    {resetLowInput, dividerRealignLow} = 2'h3;
    {primaryClock, secondaryClock, fracResult, bypassCfg} = 8'h00;
    outEnable = 8'h00; // all outputs off first
    mismatches = 0;
    total_checks = 0;
    void'($urandom(32'h2CDBCD8A));
    for (int i = 0; i < 8; i++) divRatio[i*10+:10] = 10'($urandom_range(1, 9));
    fracResult = 2'($urandom());
    tick(16);
    rstn = 1'b1;
    porReleased = 1'b1;
    tick(40); // power-down held low until supplies settle
    chk(calibrating, 1'b0);
    powerDownLowInput = 1'b1;
    waitFor(0, 1'b1, n);
    chk(n >= 16 + 8 * 4, 1'b1);
    waitFor(0, 1'b0, n);
    chk(n, CAL_C);
    waitFor(1, 1'b1, n);
    chk(n >= 2048 && n <= 2560, 1'b1);
    chk(clkOeN, 8'hFF);
    $display("test startup done");
    for (int i = 0; i < 8; i++) begin
      outEnable[i] = 1'b1; // one output at a time
      tick(3);
      chk(clkOeN, expOeN(outEnable));
    end
    chk(clkOut[5:4], fracResult);
    bypassCfg = 4'hE;
    for (int v = 0; v < 2; v++) begin
      {primaryClock, secondaryClock} = v[0] ? 2'h2 : 2'h1;
      tick(6);
      chk(clkOut[5:4], {~v[0], v[0]});
    end
    $display("test enables and bypass done");
    for (int s = 0; s < 2; s++) begin
      sameRatio = s[0];
      outEnable = 8'($urandom()) | 8'h05;
      dividerRealignLow = 1'b0;
      tick(5);
      chk(clkOeN, 8'hFF);
      dividerRealignLow = 1'b1;
      t0 = -1;
      t2 = -1;
      for (int k = 0; k < 40; k++) begin
        tick(1);
        if (t0 < 0 && clkOeN[0] === 1'b0) t0 = k;
        if (t2 < 0 && clkOeN[2] === 1'b0) t2 = k;
      end
      chk(clkOeN, expOeN(outEnable));
      chk(clkOut & expOeN(outEnable), 8'h00);
      if (s == 1) chk(16'(t0), 16'(t2));
    end
    $display("test sync done");
    resetLowInput = 1'b0;
    #1;
    chk({clkOeN, lockOut, calibrating}, {8'hFF, 2'h0});
    tick(3);
    resetLowInput = 1'b1;
    waitFor(0, 1'b1, n);
    waitFor(0, 1'b0, n);
    chk(n, CAL_C);
    $display("test restart done");
    tick(4);
    summarize();
  end
endmodule : tb_clock_output_startup_sync_sequencer
`default_nettype wire
